// *** logic/wsg_pkg.sv ***
// Constants for the wake, management interrupt and pin data register slice
// Operation
// - Enabled source with status set and global enable drives wake request.
// - Disabled wake source still records status but never drives wake request.
// - Wake enable register 3 at 07, bit n enables port 3 pin n.
// - Wake enable register 3 clears only on standby power-on reset.
// - Status register 1 at 08 holds port 1 pins; write one clears.
// - Status register 2 bits 3:0 ignore writes, follow their sources.
// - Status register 2 bits 5:4 hold port 2 pins 4,3; write one clears.
// - Parallel interrupt bit reads one while port inactive or under reset.
// - Active parallel port makes bit 0 track printer acknowledge level.
// - Enable register 1 at 0A gates port 1 status onto group interrupt.
// - Enable register 2 bits 5:0 gate status register 2 sources.
// - Enable register 2 bit 6 routes group interrupt to serial slot 2.
// - Enable register 2 bit 7 routes group interrupt to its pin.
// - Pin data registers 0C..0F, port 2 five bits, read/write, reset zero.
// - Reserved bits read back as zero.
// - Wake status bit sets on source event regardless of any enable.
package wsg_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OffWakeStatus3  = 8'h04;
  localparam logic [7:0] OffWakeEnable3  = 8'h07;
  localparam logic [7:0] OffMgmtStatus1  = 8'h08;
  localparam logic [7:0] OffMgmtStatus2  = 8'h09;
  localparam logic [7:0] OffMgmtEnable1  = 8'h0A;
  localparam logic [7:0] OffMgmtEnable2  = 8'h0B;
  localparam logic [7:0] OffPinData1     = 8'h0C;
  localparam logic [7:0] OffPinData2     = 8'h0D;
  localparam logic [7:0] OffPinData3     = 8'h0E;
  localparam logic [7:0] OffPinData4     = 8'h0F;
  localparam logic [7:0] OffEventStatus  = 8'h10;
  localparam logic [7:0] OffEventMask    = 8'h11;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RstByte         = 8'h00;
  localparam logic [7:0] RstMgmtStatus2  = 8'h01;
  localparam logic [1:0] RstEvent        = 2'h0;

  // ==========================================================================
  // Field positions
  localparam int BitParallel     = 0;
  localparam int BitPort2Pin3    = 4;
  localparam int BitPort2Pin4    = 5;
  localparam int BitSerialRoute  = 6;
  localparam int BitPinRoute     = 7;
  localparam int Port2Width      = 5;
  localparam int Status2Width    = 6;
  localparam int EvtWake         = 0;
  localparam int EvtGroup        = 1;
  localparam int EventWidth      = 2;

endpackage : wsg_pkg

// *** logic/wsg_sync.sv ***
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module wsg_sync #(
  parameter int Width = 8
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [Width-1:0] asyncIn,
  output logic      [Width-1:0] syncOut
);

  logic [Width-1:0] stage1_r;

  // ==========================================================================
  // First stage feeds only the second stage; no reset, so the pair keeps
  // tracking the pins and the level at release is already settled
  always_ff @(posedge clock) begin
    stage1_r <= asyncIn;
    syncOut  <= stage1_r;
  end

endmodule : wsg_sync

// *** logic/wsg_regs.sv ***
// Wake, management interrupt and pin data register slice
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module wsg_regs (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [7:0] address,
  input  wire logic [7:0] writeData,
  input  wire logic       writeStrobe,
  input  wire logic       readStrobe,
  output logic      [7:0] readData,
  input  wire logic [7:0] port1Pins,
  input  wire logic [4:0] port2Pins,
  input  wire logic [7:0] port3Pins,
  input  wire logic       printerAcknowledgeIn,
  input  wire logic       hardResetIn,
  input  wire logic       parallelPortActive,
  input  wire logic       secondSerialIntStatus,
  input  wire logic       firstSerialIntStatus,
  input  wire logic       floppyIntStatus,
  input  wire logic       globalWakeEnable,
  output logic            wakeRequestOutN,
  output logic            groupMgmtInterrupt,
  output logic            mgmtInterruptPinN,
  output logic            serialIrqSlot2,
  output logic      [7:0] pinDataPort1,
  output logic      [4:0] pinDataPort2,
  output logic      [7:0] pinDataPort3,
  output logic      [7:0] pinDataPort4,
  output logic            irq
);

  // ==========================================================================
  // Declarations
  logic [7:0] port1Sync;
  logic [4:0] port2Sync;
  logic [7:0] port3Sync;
  logic [1:0] miscSync;
  logic       ackSync;
  logic       hardResetSync;
  logic [7:0] port1Prev_r;
  logic [4:0] port2Prev_r;
  logic [7:0] port3Prev_r;
  logic [7:0] port1Rise;
  logic [7:0] port3Rise;
  logic       pin3Rise;
  logic       pin4Rise;
  logic [7:0] wakeStatus3_r;
  logic [7:0] wakeEnable3_r;
  logic [7:0] mgmtStatus1_r;
  logic [5:4] mgmtStatus2Hi_r;
  logic       parallelInt_r;
  logic [7:0] mgmtEnable1_r;
  logic [7:0] mgmtEnable2_r;
  logic [1:0] eventStatus_r;
  logic [1:0] eventMask_r;
  logic [5:0] mgmtStatus2;
  logic       groupNxt;
  logic       wakeNxt;
  logic       wakeActive_r;
  logic       readSel;
  logic       wrHit;
  logic [7:0] readNxt;

  // ==========================================================================
  // Pin synchronisers
  wsg_sync #(.Width(8)) syncPort1 (
    .clock   (clock),
    .reset   (reset),
    .asyncIn (port1Pins),
    .syncOut (port1Sync)
  );

  wsg_sync #(.Width(5)) syncPort2 (
    .clock   (clock),
    .reset   (reset),
    .asyncIn (port2Pins),
    .syncOut (port2Sync)
  );

  wsg_sync #(.Width(8)) syncPort3 (
    .clock   (clock),
    .reset   (reset),
    .asyncIn (port3Pins),
    .syncOut (port3Sync)
  );

  wsg_sync #(.Width(2)) syncMisc (
    .clock   (clock),
    .reset   (reset),
    .asyncIn ({hardResetIn, printerAcknowledgeIn}),
    .syncOut (miscSync)
  );

  assign ackSync       = miscSync[0];
  assign hardResetSync = miscSync[1];

  // ==========================================================================
  // Edge detection on synchronised pins
  // The previous values follow the pins through reset as well, so a pin
  // held high across reset gives no false rising edge on release
  always_ff @(posedge clock) begin
    port1Prev_r <= port1Sync;
    port2Prev_r <= port2Sync;
    port3Prev_r <= port3Sync;
  end

  assign port1Rise = port1Sync & ~port1Prev_r;
  assign port3Rise = port3Sync & ~port3Prev_r;
  assign pin3Rise  = port2Sync[3] & ~port2Prev_r[3];
  assign pin4Rise  = port2Sync[4] & ~port2Prev_r[4];

  // Writes take effect at once; the bus never waits
  assign wrHit = writeStrobe;

  // ==========================================================================
  // Wake status 3: sticky, write one clears, set wins
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : genWake
      always_ff @(posedge clock) begin
        if (reset) begin
          wakeStatus3_r[gi] <= wsg_pkg::RstByte[gi];
        end else if (port3Rise[gi]) begin
          wakeStatus3_r[gi] <= 1'b1;
        end else if (wrHit && address == wsg_pkg::OffWakeStatus3
                     && writeData[gi]) begin
          wakeStatus3_r[gi] <= 1'b0;
        end
      end

      always_ff @(posedge clock) begin
        if (reset) begin
          mgmtStatus1_r[gi] <= wsg_pkg::RstByte[gi];
        end else if (port1Rise[gi]) begin
          mgmtStatus1_r[gi] <= 1'b1;
        end else if (wrHit && address == wsg_pkg::OffMgmtStatus1
                     && writeData[gi]) begin
          mgmtStatus1_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Wake enable 3, cleared only by the standby reset
  // Hard reset and soft reset leave it alone; only the reset port clears it
  always_ff @(posedge clock) begin
    if (reset) begin
      wakeEnable3_r <= wsg_pkg::RstByte;
    end else if (wrHit && address == wsg_pkg::OffWakeEnable3) begin
      wakeEnable3_r <= writeData;
    end
  end

  // ==========================================================================
  // Status 2 upper bits: port 2 pins 3 and 4, write one clears
  // Bit 4 follows port 2 pin 3 and bit 5 port 2 pin 4; set wins
  always_ff @(posedge clock) begin
    if (reset) begin
      mgmtStatus2Hi_r[4] <= wsg_pkg::RstMgmtStatus2[4];
    end else if (pin3Rise) begin
      mgmtStatus2Hi_r[4] <= 1'b1;
    end else if (wrHit && address == wsg_pkg::OffMgmtStatus2
                 && writeData[wsg_pkg::BitPort2Pin3]) begin
      mgmtStatus2Hi_r[4] <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mgmtStatus2Hi_r[5] <= wsg_pkg::RstMgmtStatus2[5];
    end else if (pin4Rise) begin
      mgmtStatus2Hi_r[5] <= 1'b1;
    end else if (wrHit && address == wsg_pkg::OffMgmtStatus2
                 && writeData[wsg_pkg::BitPort2Pin4]) begin
      mgmtStatus2Hi_r[5] <= 1'b0;
    end
  end

  // ==========================================================================
  // Parallel interrupt status
  // Hard reset and an idle port both force the bit high; otherwise it
  // follows the synchronised acknowledge level
  always_ff @(posedge clock) begin
    if (reset) begin
      parallelInt_r <= wsg_pkg::RstMgmtStatus2[wsg_pkg::BitParallel];
    end else if (hardResetSync || !parallelPortActive) begin
      parallelInt_r <= 1'b1;
    end else begin
      parallelInt_r <= ackSync;
    end
  end

  // Low source bits follow their sources; writes do not touch them
  assign mgmtStatus2 = {mgmtStatus2Hi_r, floppyIntStatus,
                        firstSerialIntStatus, secondSerialIntStatus,
                        parallelInt_r};

  // ==========================================================================
  // Enable registers
  always_ff @(posedge clock) begin
    if (reset) begin
      mgmtEnable1_r <= wsg_pkg::RstByte;
    end else if (wrHit && address == wsg_pkg::OffMgmtEnable1) begin
      mgmtEnable1_r <= writeData;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mgmtEnable2_r <= wsg_pkg::RstByte;
    end else if (wrHit && address == wsg_pkg::OffMgmtEnable2) begin
      mgmtEnable2_r <= writeData;
    end
  end

  // ==========================================================================
  // Group interrupt and wake request
  // Route outputs are registered beside the group flag, in the same cycle
  assign groupNxt = |(mgmtStatus1_r & mgmtEnable1_r)
                  | |(mgmtStatus2
                      & mgmtEnable2_r[wsg_pkg::Status2Width-1:0]);
  assign wakeNxt  = globalWakeEnable
                  & |(wakeStatus3_r & wakeEnable3_r);

  always_ff @(posedge clock) begin
    if (reset) begin
      groupMgmtInterrupt <= 1'b0;
      mgmtInterruptPinN  <= 1'b1;
      serialIrqSlot2     <= 1'b0;
    end else begin
      groupMgmtInterrupt <= groupNxt;
      mgmtInterruptPinN  <=
        ~(groupNxt & mgmtEnable2_r[wsg_pkg::BitPinRoute]);
      serialIrqSlot2     <=
        groupNxt & mgmtEnable2_r[wsg_pkg::BitSerialRoute];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wakeActive_r    <= 1'b0;
      wakeRequestOutN <= 1'b1;
    end else begin
      wakeActive_r    <= wakeNxt;
      wakeRequestOutN <= ~wakeNxt;
    end
  end

  // ==========================================================================
  // Pin data registers
  // Port 2 keeps only its five implemented bits
  always_ff @(posedge clock) begin
    if (reset) begin
      pinDataPort1 <= wsg_pkg::RstByte;
      pinDataPort2 <= wsg_pkg::RstByte[wsg_pkg::Port2Width-1:0];
      pinDataPort3 <= wsg_pkg::RstByte;
      pinDataPort4 <= wsg_pkg::RstByte;
    end else if (wrHit) begin
      case (address)
        wsg_pkg::OffPinData1: begin
          pinDataPort1 <= writeData;
        end
        wsg_pkg::OffPinData2: begin
          pinDataPort2 <= writeData[wsg_pkg::Port2Width-1:0];
        end
        wsg_pkg::OffPinData3: begin
          pinDataPort3 <= writeData;
        end
        wsg_pkg::OffPinData4: begin
          pinDataPort4 <= writeData;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Event status, read clears, set wins
  // An edge of wake or group in the cycle of a read is kept, not lost
  assign readSel = readStrobe && address == wsg_pkg::OffEventStatus;

  always_ff @(posedge clock) begin
    if (reset) begin
      eventStatus_r <= wsg_pkg::RstEvent;
    end else begin
      eventStatus_r[wsg_pkg::EvtWake]  <= (wakeNxt & ~wakeActive_r)
        | (eventStatus_r[wsg_pkg::EvtWake] & ~readSel);
      eventStatus_r[wsg_pkg::EvtGroup] <= (groupNxt & ~groupMgmtInterrupt)
        | (eventStatus_r[wsg_pkg::EvtGroup] & ~readSel);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      eventMask_r <= wsg_pkg::RstEvent;
    end else if (wrHit && address == wsg_pkg::OffEventMask) begin
      eventMask_r <= writeData[wsg_pkg::EventWidth-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(eventStatus_r & eventMask_r);
    end
  end

  // ==========================================================================
  // Read mux, reserved bits zero
  always_comb begin
    readNxt = 8'h00;
    case (address)
      wsg_pkg::OffWakeStatus3: readNxt = wakeStatus3_r;
      wsg_pkg::OffWakeEnable3: readNxt = wakeEnable3_r;
      wsg_pkg::OffMgmtStatus1: readNxt = mgmtStatus1_r;
      wsg_pkg::OffMgmtStatus2: readNxt = {2'h0, mgmtStatus2};
      wsg_pkg::OffMgmtEnable1: readNxt = mgmtEnable1_r;
      wsg_pkg::OffMgmtEnable2: readNxt = mgmtEnable2_r;
      wsg_pkg::OffPinData1:    readNxt = pinDataPort1;
      wsg_pkg::OffPinData2:    readNxt = {3'h0, pinDataPort2};
      wsg_pkg::OffPinData3:    readNxt = pinDataPort3;
      wsg_pkg::OffPinData4:    readNxt = pinDataPort4;
      wsg_pkg::OffEventStatus: readNxt = {6'h00, eventStatus_r};
      wsg_pkg::OffEventMask:   readNxt = {6'h00, eventMask_r};
      default:                 readNxt = 8'h00;
    endcase
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (reset) begin
      readData <= 8'h00;
    end else if (readStrobe) begin
      readData <= readNxt;
    end else begin
      readData <= 8'h00;
    end
  end

endmodule : wsg_regs

// *** verif/wsg_chipset_model.sv ***
// Chipset side model latching wake and interrupt requests
`timescale 1ns/10ps
module wsg_chipset_model (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic wakeRequestOutN,
  input  wire logic mgmtInterruptPinN,
  input  wire logic serialIrqSlot2,
  output logic      wakeSeen,
  output logic      smiSeen
);
  // ==========================================================================
  // Sticky capture of each request route
  always_ff @(posedge clock) begin
    if (reset) begin
      wakeSeen <= 1'b0;
      smiSeen  <= 1'b0;
    end else begin
      if (!wakeRequestOutN) wakeSeen <= 1'b1;
      if (!mgmtInterruptPinN || serialIrqSlot2) smiSeen <= 1'b1;
    end
  end
endmodule : wsg_chipset_model

// *** verif/wsg_regs_properties.sv ***
// Concurrent checks on the register slice ports
`timescale 1ns/10ps
module wsg_regs_properties (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [7:0] address,
  input wire logic [7:0] writeData,
  input wire logic       writeStrobe,
  input wire logic       readStrobe,
  input wire logic [7:0] readData,
  input wire logic [7:0] pinDataPort1,
  input wire logic [4:0] pinDataPort2,
  input wire logic       parallelPortActive,
  input wire logic       globalWakeEnable,
  input wire logic       wakeRequestOutN,
  input wire logic       groupMgmtInterrupt,
  input wire logic       mgmtInterruptPinN,
  input wire logic       serialIrqSlot2
);
  // ==========================================================================
  // Bus steps
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence rdAt(logic [7:0] a);
    readStrobe && address == a;
  endsequence
  sequence wrAt(logic [7:0] a);
    writeStrobe && address == a;
  endsequence
  // ==========================================================================
  // Properties
  a_pin_route: assert property (
    !mgmtInterruptPinN |-> groupMgmtInterrupt)
    else $error("pin interrupt without group interrupt");
  a_slot_route: assert property (serialIrqSlot2 |-> groupMgmtInterrupt)
    else $error("slot interrupt without group interrupt");
  a_wake_global: assert property (
    !wakeRequestOutN |-> $past(globalWakeEnable))
    else $error("wake request without global enable");
  a_data1_write: assert property (
    wrAt(8'h0C) |=> pinDataPort1 == $past(writeData))
    else $error("port 1 data not written");
  a_data2_write: assert property (wrAt(8'h0D) |=>
    pinDataPort2 == $past(writeData[4:0]))
    else $error("port 2 data not written");
  a_data2_reserved: assert property (
    rdAt(8'h0D) |=> readData[7:5] == 3'h0)
    else $error("port 2 upper bits not zero");
  a_status2_reserved: assert property (
    rdAt(8'h09) |=> readData[7:6] == 2'h0)
    else $error("status 2 upper bits not zero");
  a_parallel_forced: assert property (rdAt(8'h09) ##0
    (!parallelPortActive && !$past(parallelPortActive)) |=> readData[0])
    else $error("parallel bit low while port inactive");
endmodule : wsg_regs_properties

bind wsg_regs wsg_regs_properties i_wsg_regs_properties (.clock, .reset,
  .address, .writeData, .writeStrobe, .readStrobe, .readData, .pinDataPort1,
  .pinDataPort2, .parallelPortActive, .globalWakeEnable, .wakeRequestOutN,
  .groupMgmtInterrupt, .mgmtInterruptPinN, .serialIrqSlot2);

// *** verif/testbench.sv ***
// Self-checking bench for the register slice
`timescale 1ns/10ps
module testbench;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q;} wsg_row_type;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] address = 8'h00;
  logic [7:0] writeData = 8'h00;
  logic       writeStrobe = 1'b0;
  logic       readStrobe = 1'b0;
  logic [7:0] port1Pins = 8'h00;
  logic [4:0] port2Pins = 5'h00;
  logic [7:0] port3Pins = 8'h00;
  logic       printerAcknowledgeIn = 1'b0;
  logic       hardResetIn = 1'b0;
  logic       parallelPortActive = 1'b0;
  logic [2:0] srcLevels = 3'h0;
  logic       globalWakeEnable = 1'b0;
  logic [7:0] readData, pinDataPort1, pinDataPort3, pinDataPort4;
  logic [4:0] pinDataPort2;
  logic       wakeRequestOutN, groupMgmtInterrupt, mgmtInterruptPinN;
  logic       serialIrqSlot2, irq, wakeSeen, smiSeen;
  int         badCount = 0;
  int         checksDone = 0;
  wsg_row_type rows[8] = '{'{8'h07, 8'hA5, 8'hA5}, '{8'h0A, 8'h3C, 8'h3C},
    '{8'h0B, 8'h5A, 8'h5A}, '{8'h0C, 8'h5A, 8'h5A}, '{8'h0D, 8'hFF, 8'h1F},
    '{8'h0E, 8'hC3, 8'hC3}, '{8'h0F, 8'h96, 8'h96}, '{8'h12, 8'hFF, 8'h00}};

  always #2 clock = ~clock;

  wsg_regs i_wsg_regs (.clock, .reset, .address, .writeData, .writeStrobe,
    .readStrobe, .readData, .port1Pins, .port2Pins, .port3Pins,
    .printerAcknowledgeIn, .hardResetIn, .parallelPortActive,
    .secondSerialIntStatus(srcLevels[0]), .firstSerialIntStatus(srcLevels[1]),
    .floppyIntStatus(srcLevels[2]), .globalWakeEnable, .wakeRequestOutN,
    .groupMgmtInterrupt, .mgmtInterruptPinN, .serialIrqSlot2, .pinDataPort1,
    .pinDataPort2, .pinDataPort3, .pinDataPort4, .irq);
  wsg_chipset_model i_wsg_chipset_model (.clock, .reset, .wakeRequestOutN,
    .mgmtInterruptPinN, .serialIrqSlot2, .wakeSeen, .smiSeen);

  // ==========================================================================
  // Tasks
  task automatic finish_test();
    if (badCount == 0 && checksDone > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checksDone++;
    if (g !== e) begin
      badCount++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1;
    chk(n, e, readData);
  endtask : rd
  task automatic waitGroup();
    for (int i = 0; i < 20 && groupMgmtInterrupt !== 1'b1; i++) tick(1);
    if (groupMgmtInterrupt !== 1'b1) begin
      chk("groupWait", 8'h01, 8'h00);
      finish_test();
    end
  endtask : waitGroup

  // ==========================================================================
  // Sequence
  initial begin
    #100000;
    chk("watchdog", 8'h01, 8'h00);
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    for (int k = 7; k < 16; k++) begin
      rd(8'(k), k == 9 ? 8'h01 : 8'h00, "rstVal");
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].q, "regRow");
    end
    chk("pd1", 8'h5A, pinDataPort1);
    chk("pd2", 8'h1F, {3'h0, pinDataPort2});
    chk("pd3", 8'hC3, pinDataPort3);
    chk("pd4", 8'h96, pinDataPort4);
    wr(8'h0A, 8'h01);
    wr(8'h0B, 8'hCE);
    port1Pins <= 8'h03;
    waitGroup();
    chk("pinRoute", 8'h00, {7'h00, mgmtInterruptPinN});
    chk("slotRoute", 8'h01, {7'h00, serialIrqSlot2});
    tick(1);
    chk("smiSeen", 8'h01, {7'h00, smiSeen});
    rd(8'h08, 8'h03, "status1");
    wr(8'h08, 8'h00);
    rd(8'h08, 8'h03, "status1W0");
    wr(8'h08, 8'h01);
    rd(8'h08, 8'h02, "status1W1");
    chk("groupOff", 8'h00, {7'h00, groupMgmtInterrupt});
    for (int k = 1; k < 4; k++) begin
      srcLevels <= 3'h1 << (k - 1);
      tick(3);
      wr(8'h09, 8'hFF);
      rd(8'h09, 8'h01 | (8'h01 << k), "srcHeld");
      chk("srcGroup", 8'h01, {7'h00, groupMgmtInterrupt});
      srcLevels <= 3'h0;
      tick(3);
      rd(8'h09, 8'h01, "srcGone");
    end
    port2Pins <= 5'h08;
    tick(6);
    rd(8'h09, 8'h11, "p2Pin3");
    wr(8'h09, 8'h10);
    rd(8'h09, 8'h01, "p2Clear");
    parallelPortActive <= 1'b1;
    tick(4);
    rd(8'h09, 8'h00, "ackLow");
    printerAcknowledgeIn <= 1'b1;
    tick(4);
    rd(8'h09, 8'h01, "ackHigh");
    printerAcknowledgeIn <= 1'b0;
    hardResetIn <= 1'b1;
    tick(4);
    rd(8'h09, 8'h01, "hardRst");
    rd(8'h07, 8'hA5, "wakeKeep");
    hardResetIn <= 1'b0;
    parallelPortActive <= 1'b0;
    wr(8'h07, 8'h00);
    globalWakeEnable <= 1'b1;
    port3Pins <= 8'h01;
    tick(6);
    rd(8'h04, 8'h01, "wakeSts");
    chk("wakeOff", 8'h01, {7'h00, wakeRequestOutN});
    wr(8'h07, 8'h01);
    tick(2);
    chk("wakeOn", 8'h00, {7'h00, wakeRequestOutN});
    chk("wakeSeen", 8'h01, {7'h00, wakeSeen});
    globalWakeEnable <= 1'b0;
    tick(2);
    chk("wakeGlob", 8'h01, {7'h00, wakeRequestOutN});
    chk("irqMask", 8'h00, {7'h00, irq});
    wr(8'h11, 8'h03);
    tick(2);
    chk("irqOn", 8'h01, {7'h00, irq});
    rd(8'h10, 8'h03, "evtSts");
    tick(2);
    chk("irqClr", 8'h00, {7'h00, irq});
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rd(8'h07, 8'h00, "wakeRst");
    rd(8'h08, 8'h00, "rstNoEdge");
    rd(8'h04, 8'h00, "rstWakeSts");
    chk("pd1Rst", 8'h00, pinDataPort1);
    chk("irqRst", 8'h00, {7'h00, irq});
    finish_test();
  end
endmodule : testbench
